// file: inc/bsv_map.vh
// Register offsets, field positions and clock choices of the boot strap capture block
`ifndef BSV_MAP_VH
`define BSV_MAP_VH
`define BSV_OFS_STATUS 8'h00
`define BSV_OFS_CTRL 8'h04
`define BSV_OFS_PCLK 8'h08
`define BSV_OFS_MBUS 8'h0c
`define BSV_OFS_EFFECT 8'h10
// Status field positions
`define BSV_ST_REFCLK 0
`define BSV_ST_PORT_CLOCK_MODE_STRAP_LO 1
`define BSV_ST_MADDR_LO 3
`define BSV_ST_MSLOW 7
`define BSV_ST_MERGE_LO 8
`define BSV_ST_HALT 11
`define BSV_ST_SADDR_LO 12
`define BSV_ST_SWITCH_OP_MODE_STRAP_LO 16
// Control bits
`define BSV_CTL_HALT 0
`define BSV_MBUS_PRESC_LO 0
`define BSV_MBUS_PRESC_W 8
`define BSV_MBUS_OVR 8
// Reference clock choices in MHz
`define BSV_REFCLK_LO_MHZ 100
`define BSV_REFCLK_HI_MHZ 125
`define BSV_VEC_W 20
`endif

// file: logic/bsv_sync.v
// Two-flop synchroniser for a vector of strap pins
`timescale 1ns/1ps
module bsv_sync #(
  parameter W = 20
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // bsv_sync

// file: logic/bsv_top.v
// Boot strap vector capture with AHB-Lite register access
`timescale 1ns/1ps
`include "bsv_map.vh"
// Behaviour
// (R1) Strap pins are sampled only on leaving fundamental reset and ignored at all other times.
// (R2) Captured straps are kept until the next fundamental reset and read from the status register.
// (R3) The reference clock select strap fixes the expected reference frequency with no override.
// (R4) The port clock mode strap gives the initial port clocking, replaced by a write to its register.
// (R5) The memory address strap forms master bus address bits 4 to 1 and cannot be overridden.
// (R6) The master bus slow strap sets bus speed until the prescaler field is written.
// (R7) Three merge straps combine port pairs 0-1, 2-3 and 4-5, with no override.
// (R8) A captured reset hold keeps the device halted while both management buses stay usable.
// (R9) Clearing the hold bit in the switch control register releases the device to run.
// (R10) The slave address strap sets own slave bus address bits 5 and 3 to 1, no override.
// (R11) The switch mode strap selects the operating mode and nothing can change it.
// (R12) Further setup comes from an external bus master or from serial memory loading.
// (R13) The reference select chooses 100 MHz when low and 125 MHz when high.
// (R14) Clock mode bit 0 sets port 0 common clock and bit 1 sets it for all other ports.
// (R15) The vector is captured when the global reset pin is negated.
// (R16) Captured values sit in flops loaded at release and status shows them despite overrides.
module bsv_top #(
  parameter NPORTS = 16,
  parameter [7:0] MBUS_FAST_PRESC = 8'h10,
  parameter [7:0] MBUS_SLOW_PRESC = 8'h40
) (
  // AHB-Lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Board straps and global reset pin
  input wire global_reset_n,
  input wire refclk_freq_select,
  input wire [1:0] port_clock_mode_strap,
  input wire [3:0] cfg_memory_addr_strap,
  input wire master_bus_slow_strap,
  input wire merge_pair_a,
  input wire merge_pair_b,
  input wire merge_pair_c,
  input wire reset_hold_request,
  input wire [3:0] slave_bus_addr_strap,
  input wire [3:0] switch_op_mode_strap,
  // Resulting configuration
  output reg refclk_is_125,
  output reg [NPORTS-1:0] port_common_clock,
  output reg [3:0] cfg_memory_addr,
  output reg [7:0] mgmt_bus_prescale,
  output reg [2:0] port_merge,
  output reg [3:0] slave_bus_addr,
  output reg [3:0] switch_op_mode,
  output reg device_halted,
  output reg fund_reset_active
);
  // Strap vector on its way to the capture flops
  wire [`BSV_VEC_W-1:0] raw_vec;
  wire [`BSV_VEC_W-1:0] sync_vec;
  wire [`BSV_VEC_W-1:0] straps;

  // Global reset pin synchroniser and edge stage
  reg perst_n_s1_q;
  reg perst_n_s2_q;
  reg perst_n_s3_q;
  wire release_edge;
  wire in_fund_reset;

  // Captured vector and the state software may override
  reg [`BSV_VEC_W-1:0] cap_q;
  reg halt_q;
  reg [1:0] pclk_q;
  reg [7:0] presc_q;
  reg presc_ovr_q;
  wire [7:0] presc_strap;
  wire [NPORTS-1:0] port_clk_d;
  genvar gi;

  // Named views of the captured vector
  wire cap_refclk;
  wire [1:0] cap_port_clock_mode_strap;
  wire [3:0] cap_maddr;
  wire cap_mslow;
  wire [2:0] cap_merge;
  wire cap_halt;
  wire [3:0] cap_saddr;
  wire [3:0] cap_switch_op_mode_strap;
  wire [31:0] status_word;

  // Bus tracking and write strobes
  reg ph_write_q;
  reg [7:0] ph_addr_q;
  reg [31:0] rd_d;
  wire addr_ph;
  wire rd_take;
  wire wr_ctrl;
  wire wr_pclk;
  wire wr_mbus;
  wire hold_clear;

  assign raw_vec = {switch_op_mode_strap, slave_bus_addr_strap, reset_hold_request,
                    merge_pair_c, merge_pair_b, merge_pair_a, master_bus_slow_strap,
                    cfg_memory_addr_strap, port_clock_mode_strap, refclk_freq_select};

  // Straps are static during reset but still come from pins, so they are synchronised
  bsv_sync #(
    .W(`BSV_VEC_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(raw_vec),
    .q(sync_vec)
  );
  assign straps = sync_vec;

  // Global reset pin synchroniser plus one delay stage for edge detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      perst_n_s1_q <= 1'b0;
      perst_n_s2_q <= 1'b0;
      perst_n_s3_q <= 1'b0;
    end else begin
      perst_n_s1_q <= global_reset_n;
      perst_n_s2_q <= perst_n_s1_q;
      perst_n_s3_q <= perst_n_s2_q;
    end
  end
  assign in_fund_reset = ~perst_n_s2_q;
  assign release_edge = perst_n_s2_q & ~perst_n_s3_q; // (R15)

  // Bus address phase decode
  assign addr_ph = hsel & hready & htrans[1];
  // Reads load hrdata in the address phase so it stands through the data phase
  assign rd_take = addr_ph & ~hwrite;

  // Capture flops: loaded only on the release edge, ignored elsewhere
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_q <= {`BSV_VEC_W{1'b0}};
    end else if (release_edge) begin
      cap_q <= straps; // (R1) (R16)
    end
  end

  // Field split of the captured vector
  assign cap_refclk = cap_q[`BSV_ST_REFCLK];
  assign cap_port_clock_mode_strap = cap_q[`BSV_ST_PORT_CLOCK_MODE_STRAP_LO +: 2];
  assign cap_maddr = cap_q[`BSV_ST_MADDR_LO +: 4];
  assign cap_mslow = cap_q[`BSV_ST_MSLOW];
  assign cap_merge = cap_q[`BSV_ST_MERGE_LO +: 3];
  assign cap_halt = cap_q[`BSV_ST_HALT];
  assign cap_saddr = cap_q[`BSV_ST_SADDR_LO +: 4];
  assign cap_switch_op_mode_strap = cap_q[`BSV_ST_SWITCH_OP_MODE_STRAP_LO +: 4];

  // Status word keeps the strap order; later overrides never reach it
  assign status_word = {12'h000, cap_switch_op_mode_strap, cap_saddr, cap_halt, cap_merge, cap_mslow,
                        cap_maddr, cap_port_clock_mode_strap, cap_refclk}; // (R2) (R16)

  // Write strobes, valid in the data phase while hwdata stands
  assign wr_ctrl = ph_write_q & (ph_addr_q == `BSV_OFS_CTRL);
  assign wr_pclk = ph_write_q & (ph_addr_q == `BSV_OFS_PCLK);
  assign wr_mbus = ph_write_q & (ph_addr_q == `BSV_OFS_MBUS);
  // Hold can only be cleared by software, not re-armed
  assign hold_clear = wr_ctrl & ~hwdata[`BSV_CTL_HALT];

  // Reset hold: forced during fundamental reset, set from the strap on release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_q <= 1'b1;
    end else if (in_fund_reset) begin
      halt_q <= 1'b1;
    end else if (release_edge) begin
      halt_q <= straps[`BSV_ST_HALT]; // (R8)
    // Release wins over a clear in the same cycle
    end else if (hold_clear) begin
      halt_q <= 1'b0; // (R9)
    end
  end

  // Port clocking: the strap gives the start value, a register write replaces it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_q <= 2'b00;
    end else if (in_fund_reset) begin
      pclk_q <= 2'b00;
    end else if (release_edge) begin
      pclk_q <= straps[`BSV_ST_PORT_CLOCK_MODE_STRAP_LO +: 2]; // (R4)
    end else if (wr_pclk) begin
      pclk_q <= hwdata[1:0]; // (R4)
    end
  end

  // Prescaler override; writes while in fundamental reset are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_ovr_q <= 1'b0;
      presc_q <= 8'h00;
    // A new fundamental reset drops any earlier override
    end else if (in_fund_reset | release_edge) begin
      presc_ovr_q <= 1'b0;
      presc_q <= 8'h00;
    end else if (wr_mbus) begin
      presc_q <= hwdata[`BSV_MBUS_PRESC_LO +: `BSV_MBUS_PRESC_W]; // (R6)
      presc_ovr_q <= 1'b1; // (R6)
    end
  end

  // Strap default of the master bus prescaler
  assign presc_strap = cap_mslow ? MBUS_SLOW_PRESC : MBUS_FAST_PRESC; // (R6)

  // Per-port common-clock flag: port 0 follows bit 0, every other port bit 1
  generate
    for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port_clk
      if (gi == 0) begin : g_first
        assign port_clk_d[gi] = pclk_q[0]; // (R14)
      end else begin : g_rest
        assign port_clk_d[gi] = pclk_q[1]; // (R14)
      end
    end
  endgenerate

  // Captured-only outputs; no register path reaches them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refclk_is_125 <= 1'b0;
      cfg_memory_addr <= 4'h0;
      port_merge <= 3'h0;
      slave_bus_addr <= 4'h0;
      switch_op_mode <= 4'h0;
    end else begin
      refclk_is_125 <= cap_refclk; // (R3) (R13)
      cfg_memory_addr <= cap_maddr; // (R5)
      port_merge <= cap_merge; // (R7)
      slave_bus_addr <= cap_saddr; // (R10)
      switch_op_mode <= cap_switch_op_mode_strap; // (R11)
    end
  end

  // Overridable and live outputs, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_common_clock <= {NPORTS{1'b0}};
      mgmt_bus_prescale <= 8'h00;
      device_halted <= 1'b1;
      fund_reset_active <= 1'b1;
    end else begin
      port_common_clock <= port_clk_d; // (R14)
      if (presc_ovr_q) begin
        mgmt_bus_prescale <= presc_q; // (R6)
      end else begin
        mgmt_bus_prescale <= presc_strap; // (R6)
      end
      // Bus stays live while halted so an external master can set things up
      device_halted <= halt_q | in_fund_reset; // (R8) (R12)
      fund_reset_active <= in_fund_reset;
    end
  end

  // Bus data phase tracking; zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end else if (hready) begin
      ph_write_q <= addr_ph & hwrite;
      ph_addr_q <= haddr[7:0];
    end
  end

  // Read mux; status shows captured values even after overrides
  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `BSV_OFS_STATUS: rd_d = status_word; // (R2) (R16)
      `BSV_OFS_CTRL: rd_d = {31'h0000_0000, halt_q};
      `BSV_OFS_PCLK: rd_d = {30'h0000_0000, pclk_q};
      `BSV_OFS_MBUS: rd_d = {23'h00_0000, presc_ovr_q, presc_q};
      `BSV_OFS_EFFECT: rd_d = {27'h000_0000, device_halted, pclk_q, mgmt_bus_prescale[1:0]};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Zero wait states and an OKAY answer for every transfer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is loaded at the address phase and stands until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_d;
    end
  end
endmodule // bsv_top

// file: test/bsv_board.sv
// Board strap pins and global reset pin model
`timescale 1ns/1ps
module bsv_board (
  // Clock
  input wire hclk,
  // Pins
  output logic global_reset_n,
  output logic [19:0] s
);
  initial begin
    global_reset_n = 1'b0;
    s = 20'h0;
  end
  // Straps stand well before release, then swing so a late sample shows
  task automatic fund(input logic [19:0] v);
    @(posedge hclk);
    global_reset_n <= 1'b0;
    s <= v;
    repeat (5) @(posedge hclk);
    global_reset_n <= 1'b1;
    repeat (5) @(posedge hclk);
    s <= ~v;
  endtask
endmodule // bsv_board

// file: test/bsv_top_sva.sv
// Assertions on captured strap outputs
`timescale 1ns/1ps
module bsv_top_sva #(
  parameter NPORTS = 16,
  parameter [7:0] MBUS_FAST_PRESC = 8'h10,
  parameter [7:0] MBUS_SLOW_PRESC = 8'h40
) (
  // Clock, resets, bus response and straps
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire global_reset_n,
  input wire refclk_freq_select,
  input wire [1:0] port_clock_mode_strap,
  input wire [3:0] cfg_memory_addr_strap,
  input wire master_bus_slow_strap,
  input wire merge_pair_a,
  input wire merge_pair_b,
  input wire merge_pair_c,
  input wire reset_hold_request,
  input wire [3:0] slave_bus_addr_strap,
  input wire [3:0] switch_op_mode_strap,
  // Outputs
  input wire refclk_is_125,
  input wire [NPORTS-1:0] port_common_clock,
  input wire [3:0] cfg_memory_addr,
  input wire [7:0] mgmt_bus_prescale,
  input wire [2:0] port_merge,
  input wire [3:0] slave_bus_addr,
  input wire [3:0] switch_op_mode,
  input wire device_halted,
  input wire fund_reset_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Pin to sync to output gives three edges at most
  property p_fund; !global_reset_n |-> ##[0:3] fund_reset_active; endproperty
  a_fund: assert property (p_fund) else $error("fund reset flag late");
  property p_ref; $rose(global_reset_n) |-> ##4 refclk_is_125 == $past(refclk_freq_select, 4);
  endproperty
  a_ref: assert property (p_ref) else $error("refclk select wrong");
  property p_pclk; $rose(global_reset_n) |-> ##4 port_common_clock ==
    {{(NPORTS-1){$past(port_clock_mode_strap[1], 4)}}, $past(port_clock_mode_strap[0], 4)};
  endproperty
  a_pclk: assert property (p_pclk) else $error("port clock flags wrong");
  property p_maddr; $rose(global_reset_n) |-> ##4 cfg_memory_addr == $past(cfg_memory_addr_strap, 4);
  endproperty
  a_maddr: assert property (p_maddr) else $error("memory addr wrong");
  property p_presc; $rose(global_reset_n) |-> ##4 mgmt_bus_prescale ==
    ($past(master_bus_slow_strap, 4) ? MBUS_SLOW_PRESC : MBUS_FAST_PRESC); endproperty
  a_presc: assert property (p_presc) else $error("prescale wrong");
  property p_merge; $rose(global_reset_n) |-> ##4
    port_merge == {$past(merge_pair_c, 4), $past(merge_pair_b, 4), $past(merge_pair_a, 4)};
  endproperty
  a_merge: assert property (p_merge) else $error("merge wrong");
  property p_saddr; $rose(global_reset_n) |-> ##4 slave_bus_addr == $past(slave_bus_addr_strap, 4);
  endproperty
  a_saddr: assert property (p_saddr) else $error("slave addr wrong");
  property p_mode; $rose(global_reset_n) |-> ##4 switch_op_mode == $past(switch_op_mode_strap, 4);
  endproperty
  a_mode: assert property (p_mode) else $error("switch mode wrong");
  property p_halt; $rose(global_reset_n) |-> ##4 device_halted == $past(reset_hold_request, 4);
  endproperty
  a_halt: assert property (p_halt) else $error("halt state wrong");
  property p_keep; !fund_reset_active && !$past(fund_reset_active, 2) |->
    $stable(switch_op_mode) && $stable(slave_bus_addr) && $stable(cfg_memory_addr) &&
    $stable(port_merge) && $stable(refclk_is_125); endproperty
  a_keep: assert property (p_keep) else $error("captured output moved");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
endmodule // bsv_top_sva
bind bsv_top bsv_top_sva #(.NPORTS(NPORTS), .MBUS_FAST_PRESC(MBUS_FAST_PRESC),
  .MBUS_SLOW_PRESC(MBUS_SLOW_PRESC)) u_sva (.*);

// file: test/test_boot_strap_vector_capture.sv
// Self-checking bench for the boot strap capture block
`timescale 1ns/1ps
module test_boot_strap_vector_capture;
  logic hclk, hresetn, hsel, hwrite, dph_rd;
  logic [31:0] haddr, hwdata, seed, e;
  logic [1:0] htrans;
  logic [19:0] v;
  logic [31:0] exp_q[$];
  int miscompares, comparisons, cyc, i;
  wire hreadyout, hresp, refclk_is_125, device_halted, fund_reset_active, global_reset_n;
  wire [31:0] hrdata;
  wire [15:0] port_common_clock;
  wire [3:0] cfg_memory_addr, slave_bus_addr, switch_op_mode;
  wire [7:0] mgmt_bus_prescale;
  wire [2:0] port_merge;
  wire [19:0] s;
  bsv_board u_board (.hclk(hclk), .global_reset_n(global_reset_n), .s(s));
  bsv_top u_dut (.*, .hready(hreadyout), .hsize(3'b010), .refclk_freq_select(s[0]),
    .port_clock_mode_strap(s[2:1]), .cfg_memory_addr_strap(s[6:3]),
    .master_bus_slow_strap(s[7]), .merge_pair_a(s[8]), .merge_pair_b(s[9]),
    .merge_pair_c(s[10]), .reset_hold_request(s[11]), .slave_bus_addr_strap(s[15:12]),
    .switch_op_mode_strap(s[19:16]));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      miscompares++;
      $display("[FAIL] %0t exp %h got %h", $time, ex, got);
    end
  endtask
  // Reads note their expectation; the monitor below compares
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    if (!w) exp_q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    // Output flops follow a register write one edge later
    repeat (2) @(negedge hclk);
  endtask
  always @(posedge hclk) begin
    if (dph_rd && hreadyout) begin
      e = exp_q.pop_front();
      chk(e, hrdata);
    end
    dph_rd <= hsel && hreadyout && htrans[1] && !hwrite;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    seed = 32'h60df;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = seed[19:0];
      v[11] = i[0];
      u_board.fund(v);
      bus(0, 32'h00, {12'h0, v});
      chk(32'h0, fund_reset_active);
      repeat (8) @(posedge hclk);
      bus(0, 32'h00, {12'h0, v});
      chk(v[11], device_halted);
      bus(1, 32'h04, 32'h1);
      chk(v[11], device_halted);
      bus(0, 32'h04, {31'h0, v[11]});
      bus(1, 32'h04, 32'h0);
      chk(1'b0, device_halted);
      bus(0, 32'h04, 32'h0);
    end
    bus(1, 32'h08, {30'h0, ~v[2:1]});
    chk({~v[2], ~v[1]}, port_common_clock[1:0]);
    bus(0, 32'h08, {30'h0, ~v[2:1]});
    bus(1, 32'h00, 32'hffff_ffff);
    bus(0, 32'h00, {12'h0, v});
    bus(1, 32'h0c, 32'h5a);
    chk(32'h5a, mgmt_bus_prescale);
    bus(0, 32'h0c, 32'h15a);
    bus(0, 32'h10, {27'h0, 1'b0, ~v[2:1], 2'b10});
    bus(0, 32'h20, 32'h0);
    repeat (3) @(posedge hclk);
    end_sim();
  end
endmodule // test_boot_strap_vector_capture
